// >>> pkg/lpdpc_pkg.sv
// Constants and types for the power-down and clock-stop tracker
package lpdpc_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS = 50000;
  localparam int unsigned T_XP_PS       = 7500;
  localparam int unsigned XP_RAW_CYC    = (T_XP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned XP_CYC        = (XP_RAW_CYC < 1) ? 1 : XP_RAW_CYC;
  localparam int unsigned CLK_STABLE_CYC = 2;

  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;
  localparam logic [CNT_W-1:0] XP_LOAD    = CNT_W'(XP_CYC);
  localparam logic [CNT_W-1:0] CLKRS_LOAD = CNT_W'(CLK_STABLE_CYC + XP_CYC);

  // ==========================================================================
  // Command encodings on CA2..CA0
  // ==========================================================================
  localparam int unsigned CA_W = 3;
  localparam logic [CA_W-1:0] CA_NOP = 3'h7;
  localparam logic [CA_W-1:0] CA_DPD = 3'h3;

  // ==========================================================================
  // Power states
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_PD,
    ST_DPD,
    ST_XP,
    ST_CLKRS,
    ST_INIT
  } lpdpc_state_e;

  typedef struct packed {
    lpdpc_state_e     state;
    logic             cke_prev;
    logic [CNT_W-1:0] cnt;
    logic             pd;
    logic             dpd;
    logic             in_buf_en;
    logic             out_buf_en;
    logic             core_pwr_en;
    logic             need_init;
    logic             ready;
    logic             nop;
    logic             illegal;
  } lpdpc_st_s;

  localparam lpdpc_st_s ST_RESET = '{
    state:       ST_ACTIVE,
    cke_prev:    1'b1,
    cnt:         CNT_ZERO,
    pd:          1'b0,
    dpd:         1'b0,
    in_buf_en:   1'b1,
    out_buf_en:  1'b1,
    core_pwr_en: 1'b1,
    need_init:   1'b0,
    ready:       1'b1,
    nop:         1'b0,
    illegal:     1'b0
  };

endpackage : lpdpc_pkg

// >>> pkg/lpdpc_cmd_if.sv
// Carrier between the tracker and its command decoder
`timescale 1ns/1ps
`default_nettype none
interface lpdpc_cmd_if;
  import lpdpc_pkg::*;
  logic            cke;
  logic            cke_prev;
  logic            cs_n;
  logic [CA_W-1:0] ca;
  logic            is_nop;
  logic            is_pd_entry;
  logic            is_dpd_entry;
  logic            is_exit;

  modport dec (input cke, cke_prev, cs_n, ca,
               output is_nop, is_pd_entry, is_dpd_entry, is_exit);
  modport ctl (output cke, cke_prev, cs_n, ca,
               input is_nop, is_pd_entry, is_dpd_entry, is_exit);
endinterface : lpdpc_cmd_if
`default_nettype wire

// >>> verilog/lpdpc_cmd_dec.sv
// Decoder of power-state commands from CKE, CS_n and CA2..CA0
`timescale 1ns/1ps
`default_nettype none
module lpdpc_cmd_dec
  import lpdpc_pkg::*;
(
  lpdpc_cmd_if.dec cmd
);

  // ==========================================================================
  // Decode
  // ==========================================================================
  always_comb begin
    cmd.is_nop       = (cmd.cke == cmd.cke_prev)
                       && (cmd.cs_n || (cmd.ca == CA_NOP));
    cmd.is_pd_entry  = cmd.cke_prev && !cmd.cke && cmd.cs_n;
    cmd.is_dpd_entry = cmd.cke_prev && !cmd.cke && !cmd.cs_n
                       && (cmd.ca == CA_DPD);
    cmd.is_exit      = !cmd.cke_prev && cmd.cke && cmd.cs_n;
  end

endmodule : lpdpc_cmd_dec
`default_nettype wire

// >>> verilog/lpdpc_pwr_ctrl.sv
// Device-side power-down, deep power-down and clock-stop state tracker
//
// How it works
// - CKE low with CS_n low, CA0 high, CA1 high, CA2 low enters deep power-down.
// - Deep power-down may switch off input, output buffers and core power.
// - CKE and CS_n high leave deep power-down; full initialisation follows.
// - After clock restart with CKE high, ready after two cycles plus tXP.
// - NOP only counts when CKE is unchanged from the previous cycle.
// - NOP is CS_n high, or CS_n low with CA0..CA2 high; aborts nothing.
// - CKE low with CS_n high enters power-down; CKE was high before.
`timescale 1ns/1ps
`default_nettype none
module lpdpc_pwr_ctrl
  import lpdpc_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            ce_i,
  // Command pins
  input  wire logic            cke_i,
  input  wire logic            cs_n_i,
  input  wire logic [CA_W-1:0] ca_i,
  // Core status
  input  wire logic            op_busy_i,
  input  wire logic            clk_restart_i,
  input  wire logic            init_done_i,
  // Power state
  output logic                 pd_o,
  output logic                 dpd_o,
  output logic                 in_buf_en_o,
  output logic                 out_buf_en_o,
  output logic                 core_pwr_en_o,
  // Readiness and events
  output logic                 need_init_o,
  output logic                 ready_o,
  output logic                 nop_o,
  output logic                 illegal_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  lpdpc_st_s   st_r;
  lpdpc_st_s   st_nxt;
  lpdpc_cmd_if cmd ();

  // ==========================================================================
  // Command decoder
  // ==========================================================================
  assign cmd.cke      = cke_i;
  assign cmd.cke_prev = st_r.cke_prev;
  assign cmd.cs_n     = cs_n_i;
  assign cmd.ca       = ca_i;

  lpdpc_cmd_dec u_dec (
    .cmd (cmd)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    st_nxt          = st_r;
    st_nxt.cke_prev = cke_i;
    st_nxt.nop      = cmd.is_nop;
    // CKE must not fall while an operation runs
    if (st_r.cke_prev && !cke_i && op_busy_i) begin
      st_nxt.illegal = 1'b1;
    end
    unique case (st_r.state)
      ST_ACTIVE: begin
        if (cmd.is_dpd_entry) begin
          st_nxt.state       = ST_DPD;
          st_nxt.dpd         = 1'b1;
          st_nxt.ready       = 1'b0;
          st_nxt.in_buf_en   = 1'b0;
          st_nxt.out_buf_en  = 1'b0;
          st_nxt.core_pwr_en = 1'b0;
        end else if (cmd.is_pd_entry) begin
          st_nxt.state      = ST_PD;
          st_nxt.pd         = 1'b1;
          st_nxt.ready      = 1'b0;
          st_nxt.in_buf_en  = 1'b0;
          st_nxt.out_buf_en = 1'b0;
        end else if (clk_restart_i && cke_i) begin
          st_nxt.state = ST_CLKRS;
          st_nxt.cnt   = CLKRS_LOAD;
          st_nxt.ready = 1'b0;
        end else if (!st_r.cke_prev && !cke_i) begin
          st_nxt.illegal = 1'b1;
        end
      end
      ST_PD: begin
        if (cmd.is_exit) begin
          st_nxt.state      = ST_XP;
          st_nxt.cnt        = XP_LOAD;
          st_nxt.pd         = 1'b0;
          st_nxt.in_buf_en  = 1'b1;
          st_nxt.out_buf_en = 1'b1;
        end else if (cke_i) begin
          st_nxt.illegal = 1'b1;
        end
      end
      ST_DPD: begin
        if (cmd.is_exit) begin
          st_nxt.state       = ST_INIT;
          st_nxt.dpd         = 1'b0;
          st_nxt.need_init   = 1'b1;
          st_nxt.in_buf_en   = 1'b1;
          st_nxt.out_buf_en  = 1'b1;
          st_nxt.core_pwr_en = 1'b1;
        end else if (cke_i) begin
          st_nxt.illegal = 1'b1;
        end
      end
      ST_XP, ST_CLKRS: begin
        if (!cke_i) begin
          st_nxt.illegal = 1'b1;
        end
        if (st_r.cnt == CNT_ONE) begin
          st_nxt.state = ST_ACTIVE;
          st_nxt.cnt   = CNT_ZERO;
          st_nxt.ready = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt - CNT_ONE;
        end
      end
      ST_INIT: begin
        if (init_done_i) begin
          st_nxt.state     = ST_ACTIVE;
          st_nxt.need_init = 1'b0;
          st_nxt.ready     = 1'b1;
          // A violation in the same cycle as the clear still sets the flag
          st_nxt.illegal   = st_r.cke_prev && !cke_i && op_busy_i;
        end else if (cmd.is_dpd_entry) begin
          st_nxt.state       = ST_DPD;
          st_nxt.dpd         = 1'b1;
          st_nxt.need_init   = 1'b0;
          st_nxt.in_buf_en   = 1'b0;
          st_nxt.out_buf_en  = 1'b0;
          st_nxt.core_pwr_en = 1'b0;
        end
      end
      default: begin
        st_nxt = ST_RESET;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= ST_RESET;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign pd_o          = st_r.pd;
  assign dpd_o         = st_r.dpd;
  assign in_buf_en_o   = st_r.in_buf_en;
  assign out_buf_en_o  = st_r.out_buf_en;
  assign core_pwr_en_o = st_r.core_pwr_en;
  assign need_init_o   = st_r.need_init;
  assign ready_o       = st_r.ready;
  assign nop_o         = st_r.nop;
  assign illegal_o     = st_r.illegal;

endmodule : lpdpc_pwr_ctrl
`default_nettype wire

// >>> dv/lpdpc_pwr_ctrl_assertions.sv
// Checker on the power-state tracker ports
`timescale 1ns/1ps
`default_nettype none
module lpdpc_pwr_ctrl_assertions
  import lpdpc_pkg::*;
(
  // Pins and status
  input wire logic            clk_i, rst_n_i, ce_i, cke_i, cs_n_i,
  input wire logic [CA_W-1:0] ca_i,
  input wire logic            op_busy_i, clk_restart_i, init_done_i,
  // Power state
  input wire logic            pd_o, dpd_o, in_buf_en_o, out_buf_en_o,
  input wire logic            core_pwr_en_o, need_init_o, ready_o, nop_o, illegal_o
);
  // ==========================================================
  // CKE of the last enabled edge, as the tracker sees it
  logic cke_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cke_q <= 1'b1;
    end else if (ce_i) begin
      cke_q <= cke_i;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_fall;
    ce_i && cke_q && !cke_i && ready_o;
  endsequence
  sequence s_wait;
    !ready_o [*3] ##1 ready_o;
  endsequence
  AST_DPD_ENTER:
    assert property (s_fall ##0 (!op_busy_i && !cs_n_i && ca_i == CA_DPD) |=> dpd_o && !ready_o)
    else $error("deep power-down not entered");
  AST_DPD_OFF:
    assert property (dpd_o |-> !(in_buf_en_o || out_buf_en_o || core_pwr_en_o))
    else $error("buffers on in deep power-down");
  AST_PD_ENTER:
    assert property (s_fall ##0 (!op_busy_i && cs_n_i) |=> pd_o && !dpd_o && !in_buf_en_o)
    else $error("power-down not entered");
  AST_DPD_EXIT:
    assert property (ce_i && dpd_o && !cke_q && cke_i && cs_n_i |=> !dpd_o && need_init_o && !ready_o)
    else $error("bad deep power-down exit");
  AST_INIT_WAIT:
    assert property (ce_i && need_init_o && !init_done_i |=> !ready_o)
    else $error("ready before init");
  AST_NOP:
    assert property (ce_i && cke_i == cke_q && (cs_n_i || ca_i == CA_NOP) |=> nop_o)
    else $error("nop missed");
  AST_NOP_CKE:
    assert property (ce_i && cke_i != cke_q |=> !nop_o)
    else $error("nop with cke change");
  AST_RESTART:
    assert property (ce_i && clk_restart_i && cke_i && ready_o |=> s_wait)
    else $error("bad restart wait");
  AST_BUSY:
    assert property (s_fall ##0 op_busy_i |=> illegal_o)
    else $error("busy cke fall not flagged");
endmodule : lpdpc_pwr_ctrl_assertions
bind lpdpc_pwr_ctrl lpdpc_pwr_ctrl_assertions lpdpc_pwr_ctrl_assertions_i (.clk_i, .rst_n_i,
  .ce_i, .cke_i, .cs_n_i, .ca_i, .op_busy_i, .clk_restart_i, .init_done_i, .pd_o, .dpd_o,
  .in_buf_en_o, .out_buf_en_o, .core_pwr_en_o, .need_init_o, .ready_o, .nop_o, .illegal_o);
`default_nettype wire

// >>> dv/lpdpc_ctrl_model.sv
// Memory controller model driving CKE, chip select and CA
`timescale 1ns/1ps
`default_nettype none
module lpdpc_ctrl_model
  import lpdpc_pkg::*;
(
  // Clock
  input  wire logic            clk_i,
  // Command pins
  output logic                 cke_o,
  output logic                 cs_n_o,
  output logic [CA_W-1:0]      ca_o
);
  // ==========================================================
  // Pin drive
  logic            sel_r = 1'b0;
  logic [CA_W-1:0] ca_r  = CA_NOP;
  logic [CA_W-1:0] scr_r = 3'h5;
  initial cke_o = 1'b1;
  // Deselected CA lines keep changing
  always @(negedge clk_i) scr_r <= ~scr_r;
  assign ca_o   = sel_r ? ca_r : scr_r;
  assign cs_n_o = ~sel_r;
  // Called just after a falling edge
  task send(input logic k, input logic s, input logic [CA_W-1:0] c);
    cke_o = k;
    sel_r = s;
    ca_r  = c;
  endtask : send
endmodule : lpdpc_ctrl_model
`default_nettype wire

// >>> dv/lpdpc_pwr_ctrl_test.sv
// Self-checking bench for the power-state tracker
`timescale 1ns/1ps
`default_nettype none
module lpdpc_pwr_ctrl_test;
  import lpdpc_pkg::*;
  // ==========================================================
  // Signals
  logic            clk_i = 1'b0;
  logic            rst_n_i = 1'b0;
  logic            busy = 1'b0;
  logic            ce = 1'b1;
  logic            rstrt = 1'b0;
  logic            idone = 1'b0;
  wire logic       cke, cs_n;
  wire logic [2:0] ca;
  wire logic [8:0] outs;
  logic [17:0]     q[$];
  logic [17:0]     n;
  int              num_errors = 0;
  int              checks = 0;
  int              i;
  always #25 clk_i = ~clk_i;
  lpdpc_ctrl_model lpdpc_ctrl_model_i (.clk_i, .cke_o(cke), .cs_n_o(cs_n), .ca_o(ca));
  lpdpc_pwr_ctrl lpdpc_pwr_ctrl_i (.clk_i, .rst_n_i, .ce_i(ce), .cke_i(cke), .cs_n_i(cs_n),
    .ca_i(ca), .op_busy_i(busy), .clk_restart_i(rstrt), .init_done_i(idone),
    .pd_o(outs[8]), .dpd_o(outs[7]), .in_buf_en_o(outs[6]), .out_buf_en_o(outs[5]),
    .core_pwr_en_o(outs[4]), .need_init_o(outs[3]), .ready_o(outs[2]), .nop_o(outs[1]),
    .illegal_o(outs[0]));
  // ==========================================================
  // Tasks
  task automatic step(input logic k, s, input logic [2:0] c, input logic [8:0] e,
                      input logic [8:0] m = 9'h1FF);
    @(negedge clk_i);
    lpdpc_ctrl_model_i.send(k, s, c);
    q.push_back({m, e});
  endtask : step
  task automatic nop(input logic k, input logic [8:0] e);
    step(k, 1'($urandom % 2), CA_NOP, e);
  endtask : nop
  task automatic rst;
    rst_n_i = 1'b0;
    busy = 1'b0;
    lpdpc_ctrl_model_i.send(1'b1, 1'b0, CA_NOP);
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
  endtask : rst
  task automatic complete_run;
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  // ==========================================================
  // Monitor
  always @(posedge clk_i) begin
    #1;
    if (q.size() > 0) begin
      n = q.pop_front();
      checks++;
      if (((outs ^ n[8:0]) & n[17:9]) !== 9'h000) begin
        num_errors++;
        $display("[ERR] %0t outputs %h expected %h", $time, outs, n[8:0]);
      end
    end
  end
  initial begin
    #(2000 * 50);
    num_errors++;
    complete_run();
  end
  // ==========================================================
  // Tests
  initial begin
    i = $urandom(32'hDD19);
    rst();
    for (i = 0; i < 4; i++) begin
      nop(1'b1, 9'h076);
      step(1'b1, 1'b1, 3'($urandom % 7), 9'h074);
    end
    step(1'b0, 1'b0, CA_NOP, 9'h110);
    nop(1'b0, 9'h112);
    step(1'b1, 1'b0, CA_NOP, 9'h070);
    for (i = 1; i < XP_CYC; i++) nop(1'b1, 9'h072);
    nop(1'b1, 9'h076);
    step(1'b0, 1'b1, CA_DPD, 9'h080);
    nop(1'b0, 9'h082);
    step(1'b1, 1'b0, CA_NOP, 9'h078);
    nop(1'b1, 9'h07A);
    nop(1'b1, 9'h076);
    idone = 1'b1;
    nop(1'b1, 9'h072);
    idone = 1'b0;
    rstrt = 1'b1;
    for (i = 1; i < CLK_STABLE_CYC + XP_CYC; i++) begin
      nop(1'b1, 9'h072);
      rstrt = 1'b0;
    end
    nop(1'b1, 9'h076);
    step(1'b0, 1'b0, CA_NOP, 9'h001, 9'h001);
    busy = 1'b1;
    step(1'b0, 1'b0, CA_NOP, 9'h001, 9'h001);
    wait (q.size() == 0);
    @(negedge clk_i);
    rst();
    ce = 1'b0;
    step(1'b0, 1'b0, CA_NOP, 9'h074);
    @(posedge clk_i);
    ce <= 1'b1;
    nop(1'b1, 9'h076);
    wait (q.size() == 0);
    @(negedge clk_i);
    complete_run();
  end
endmodule : lpdpc_pwr_ctrl_test
`default_nettype wire
